/* verilog/sdh_pkg.sv */
/*
  Package for the SD/eMMC host controller core: register offsets, field
  positions, reset values, command indices, timing counts and state enums.
  Assumes a 32-bit AXI4-Lite register bus and a card clock on a pin.
*/
package sdh_pkg;

  // ***************************************************************
  // Register byte offsets
  // ***************************************************************
  localparam logic [7:0] SDH_OFF_BLOCK_SIZE  = 8'h00;
  localparam logic [7:0] SDH_OFF_BLOCK_COUNT = 8'h04;
  localparam logic [7:0] SDH_OFF_ARGUMENT    = 8'h08;
  localparam logic [7:0] SDH_OFF_XFER_MODE   = 8'h0C;
  localparam logic [7:0] SDH_OFF_COMMAND     = 8'h10;
  localparam logic [7:0] SDH_OFF_HOST_CTRL   = 8'h14;
  localparam logic [7:0] SDH_OFF_GAP_CTRL    = 8'h18;
  localparam logic [7:0] SDH_OFF_NORM_STAT   = 8'h1C;
  localparam logic [7:0] SDH_OFF_ERR_STAT    = 8'h20;
  localparam logic [7:0] SDH_OFF_PRESENT     = 8'h24;
  localparam logic [7:0] SDH_OFF_SW_RESET    = 8'h28;
  localparam logic [7:0] SDH_OFF_RESPONSE    = 8'h2C;

  // Number of card-domain synchronized registers
  localparam int SDH_NUM_SYNC = 7;
  localparam logic [2:0] SDH_SYNC_ID_ARG  = 3'h2;
  localparam logic [2:0] SDH_SYNC_ID_MODE = 3'h3;
  localparam logic [2:0] SDH_SYNC_ID_CMD  = 3'h4;
  localparam logic [2:0] SDH_SYNC_ID_HOST = 3'h5;
  localparam logic [2:0] SDH_SYNC_ID_GAP  = 3'h6;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int SDH_MODE_ACMD_LSB   = 2;   // auto_command_enable_field [3:2]
  localparam int SDH_MODE_MULTI_BIT  = 5;
  localparam int SDH_MODE_READ_BIT   = 4;
  localparam int SDH_MODE_STREAM_BIT = 6;
  localparam int SDH_CMD_IDX_LSB     = 8;   // command index [13:8]
  localparam int SDH_CMD_DATA_BIT    = 5;
  localparam int SDH_CMD_RESUME_BIT  = 6;
  localparam int SDH_HOST_EMMC_BIT   = 0;
  localparam int SDH_GAP_STOP_BIT    = 0;
  localparam int SDH_NORM_CMD_DONE   = 0;
  localparam int SDH_NORM_XFER_DONE  = 1;
  localparam int SDH_NORM_GAP_EVENT  = 2;
  localparam int SDH_ERR_DATA_TMO    = 4;

  localparam logic [1:0]  SDH_ACMD_OFF   = 2'h0;
  localparam logic [31:0] SDH_RESET_ZERO = 32'h0000_0000;

  // ***************************************************************
  // Command indices: those with possible busy, plus CMD13 and CMD19
  // ***************************************************************
  localparam logic [5:0] SDH_CMD5  = 6'h05;
  localparam logic [5:0] SDH_CMD6  = 6'h06;
  localparam logic [5:0] SDH_CMD12 = 6'h0C;
  localparam logic [5:0] SDH_CMD13 = 6'h0D;
  localparam logic [5:0] SDH_CMD19 = 6'h13;
  localparam logic [5:0] SDH_CMD28 = 6'h1C;
  localparam logic [5:0] SDH_CMD29 = 6'h1D;
  localparam logic [5:0] SDH_CMD38 = 6'h26;

  // ***************************************************************
  // Card clock timing
  // ***************************************************************
  localparam logic [3:0] SDH_NRC_CLOCKS    = 4'h8;  // response end to next start
  localparam logic [3:0] SDH_RESUME_CLOCKS = 4'h2;  // response end to write restart
  localparam logic [3:0] SDH_TURN_CLOCKS   = 4'h2;  // FSM to pin turnaround

  // ***************************************************************
  // States
  // ***************************************************************
  typedef enum logic [2:0] {
    SDH_ST_IDLE  = 3'b000,
    SDH_ST_RESP  = 3'b001,
    SDH_ST_BUSY  = 3'b010,
    SDH_ST_GAP   = 3'b011,
    SDH_ST_DATA  = 3'b100,
    SDH_ST_PAUSE = 3'b101,
    SDH_ST_DRAIN = 3'b110
  } sdh_state_type;

endpackage

/* verilog/sdh_sync_if.sv */
/*
  Interface carrying one register write from the bus side to the card
  side of the controller. Assumes both ends share aclk.
*/
`timescale 1ns/10ps
interface sdh_sync_if;
  logic        req;
  logic        ack;
  logic [2:0]  id;
  logic [31:0] data;
  logic        pend;
  logic [31:0] shadow [7];
  modport src (output req, output id, output data, input ack, input pend);
  modport dst (input req, input id, input data, output ack, output pend,
               output shadow);
endinterface

/* verilog/sdh_sync.sv */
/*
  Card-domain register shadow: takes each register write by a
  request/acknowledge handshake, applied on a card clock edge.
  Assumes card_clk_rise is a one-cycle pulse from a synchronised pin.
*/
`timescale 1ns/10ps
module sdh_sync
  import sdh_pkg::*;
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic card_clk_rise,
  // Write channel
  sdh_sync_if.dst   wr
);
  import sdh_pkg::*;

  logic        held;
  logic [2:0]  held_id;
  logic [31:0] held_data;

  // Capture a request only when idle, so back to back writes queue at the source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held      <= 1'b0;
      held_id   <= 3'h0;
      held_data <= SDH_RESET_ZERO;
      wr.ack    <= 1'b0;
    end else begin
      wr.ack <= 1'b0;
      if (!held && wr.req && !wr.ack) begin
        held      <= 1'b1;
        held_id   <= wr.id;
        held_data <= wr.data;
      end else if (held && card_clk_rise) begin
        held   <= 1'b0;
        wr.ack <= 1'b1;
      end
    end
  end

  assign wr.pend = held;

  genvar g;
  generate
    for (g = 0; g < SDH_NUM_SYNC; g++) begin : gen_shadow
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          wr.shadow[g] <= SDH_RESET_ZERO;
        end else if (held && card_clk_rise && held_id == 3'(g)) begin
          wr.shadow[g] <= held_data;
        end
      end
    end
  endgenerate
endmodule

/* verilog/sdh_core.sv */
/*
  SD/eMMC host controller core: AXI4-Lite registers, command/response
  sequencing with busy handling, read/write data flow control and
  card clock gating. Assumes the card clock and DAT/CMD lines arrive as
  pins, sampled here through two flip-flops.
*/
`timescale 1ns/10ps
module sdh_core
  import sdh_pkg::*;
#(
  parameter int FIFO_BLOCKS = 2,
  parameter int TMO_CLOCKS  = 4096
)(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Card pins
  input  wire logic        card_clk_in,
  input  wire logic        dat0_in,
  input  wire logic        resp_end_in,
  input  wire logic        block_done_in,
  input  wire logic        card_detect_input,
  input  wire logic        write_protect_input,
  output logic             card_clk_en,
  output logic             cmd_start,
  output logic [5:0]       cmd_index,
  output logic [31:0]      cmd_arg,
  output logic             dat_out,
  output logic             dat_oe,
  // Data buffer status from the DMA side
  input  wire logic        block_to_mem
);
  import sdh_pkg::*;

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  logic [1:0] clk_s, dat0_s, rend_s, bdone_s, cd_s, wp_s;
  logic       clk_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_s <= 2'h0; dat0_s <= 2'h3; rend_s <= 2'h0;
      bdone_s <= 2'h0; cd_s <= 2'h0; wp_s <= 2'h0; clk_q <= 1'b0;
    end else begin
      clk_s   <= {clk_s[0], card_clk_in};
      dat0_s  <= {dat0_s[0], dat0_in};
      rend_s  <= {rend_s[0], resp_end_in};
      bdone_s <= {bdone_s[0], block_done_in};
      cd_s    <= {cd_s[0], card_detect_input};
      wp_s    <= {wp_s[0], write_protect_input};
      clk_q   <= clk_s[1];
    end
  end
  logic rise, card_busy, resp_end, blk_done;
  assign rise      = clk_s[1] & ~clk_q;
  assign card_busy = ~dat0_s[1];
  assign resp_end  = rend_s[1];
  assign blk_done  = bdone_s[1];

  // ***************************************************************
  // Busy command decode
  // ***************************************************************
  function automatic logic busy_cmd(input logic [5:0] idx, input logic emmc);
    busy_cmd = (idx == SDH_CMD12) || (idx == SDH_CMD28) ||
               (idx == SDH_CMD29) || (idx == SDH_CMD38) ||
               (emmc && ((idx == SDH_CMD5) || (idx == SDH_CMD6)));
  endfunction

  // ***************************************************************
  // Register write crossing
  // ***************************************************************
  sdh_sync_if sif ();
  sdh_sync u_sync (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .card_clk_rise (rise),
    .wr            (sif.dst)
  );

  logic        aw_ok, w_ok, soft_rst, fire;
  logic [7:0]  aw_q;
  logic [31:0] w_q;
  logic [31:0] norm_stat, err_stat, resp_reg;
  logic        wr_go;
  // A write is only accepted when the crossing is free
  assign wr_go = aw_ok && w_ok && !s_axi_bvalid && !sif.req && !sif.pend;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok <= 1'b0; w_ok <= 1'b0; aw_q <= 8'h00; w_q <= SDH_RESET_ZERO;
      s_axi_awready <= 1'b0; s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_ok && !s_axi_awready;
      s_axi_wready  <= !w_ok && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok <= 1'b1; aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok <= 1'b1; w_q <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_ok <= 1'b0; w_ok <= 1'b0;
      end
    end
  end

  // Write response and crossing request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0; s_axi_bresp <= 2'h0;
      sif.req <= 1'b0; sif.id <= 3'h0; sif.data <= SDH_RESET_ZERO;
      soft_rst <= 1'b0; fire <= 1'b0;
    end else begin
      soft_rst <= 1'b0;
      // Start the command only once its word has reached the card side
      fire     <= sif.ack && (sif.id == SDH_SYNC_ID_CMD);
      if (sif.ack) sif.req <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        if (aw_q[7:2] <= SDH_OFF_GAP_CTRL[7:2]) begin
          sif.req  <= 1'b1;
          sif.id   <= aw_q[4:2];
          sif.data <= w_q;
        end else if (aw_q == SDH_OFF_SW_RESET) begin
          soft_rst <= w_q[0];
        end else if (aw_q != SDH_OFF_NORM_STAT && aw_q != SDH_OFF_ERR_STAT) begin
          s_axi_bresp <= 2'h2;
        end
      end
    end
  end

  // ***************************************************************
  // Command and data state machine (card side)
  // ***************************************************************
  sdh_state_type st;
  logic [3:0]  gap_cnt, turn_cnt;
  logic        cmd_pend, pend_busy, auto_pend, bus_test, read_xfer, resume_wr;
  logic [7:0]  fifo_lvl;
  logic [15:0] tmo_cnt;
  logic [31:0] mode_r, host_r, gap_r, cmd_r;
  assign mode_r = sif.shadow[SDH_SYNC_ID_MODE];
  assign host_r = sif.shadow[SDH_SYNC_ID_HOST];
  assign gap_r  = sif.shadow[SDH_SYNC_ID_GAP];
  assign cmd_r  = sif.shadow[SDH_SYNC_ID_CMD];

  logic set_cmd_done, set_xfer_done, set_gap, set_tmo;

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      st <= SDH_ST_IDLE; gap_cnt <= 4'h0; turn_cnt <= 4'h0;
      cmd_pend <= 1'b0; pend_busy <= 1'b0; auto_pend <= 1'b0;
      bus_test <= 1'b0; read_xfer <= 1'b0; resume_wr <= 1'b0;
      fifo_lvl <= 8'h00; tmo_cnt <= 16'h0000;
      card_clk_en <= 1'b0; cmd_start <= 1'b0; cmd_index <= 6'h00;
      cmd_arg <= SDH_RESET_ZERO; dat_out <= 1'b1; dat_oe <= 1'b0;
      set_cmd_done <= 1'b0; set_xfer_done <= 1'b0; set_gap <= 1'b0; set_tmo <= 1'b0;
    end else begin
      cmd_start <= 1'b0;
      set_cmd_done <= 1'b0; set_xfer_done <= 1'b0; set_gap <= 1'b0; set_tmo <= 1'b0;
      if (fire) cmd_pend <= 1'b1;
      if (rise && gap_cnt != 4'h0) gap_cnt <= gap_cnt - 4'h1;
      if (block_to_mem && fifo_lvl != 8'h00) fifo_lvl <= fifo_lvl - 8'h01;
      case (st)
        SDH_ST_IDLE: begin
          card_clk_en <= 1'b1;
          dat_oe      <= 1'b0;
          // Auto command waits for the same response-end spacing (gap_cnt) as any command
          if ((cmd_pend || auto_pend) && gap_cnt == 4'h0 && rise) begin
            cmd_start <= 1'b1;
            cmd_index <= auto_pend ? SDH_CMD12 : cmd_r[SDH_CMD_IDX_LSB +: 6];
            cmd_arg   <= sif.shadow[SDH_SYNC_ID_ARG];
            pend_busy <= busy_cmd(auto_pend ? SDH_CMD12 : cmd_r[SDH_CMD_IDX_LSB +: 6],
                                  host_r[SDH_HOST_EMMC_BIT]);
            if (!auto_pend && cmd_r[SDH_CMD_IDX_LSB +: 6] == SDH_CMD19) bus_test <= 1'b1;
            resume_wr <= !auto_pend && cmd_r[SDH_CMD_RESUME_BIT];
            read_xfer <= mode_r[SDH_MODE_READ_BIT];
            cmd_pend  <= 1'b0;
            auto_pend <= 1'b0;
            st        <= SDH_ST_RESP;
          end
        end
        SDH_ST_RESP: if (resp_end) begin
          gap_cnt      <= SDH_NRC_CLOCKS;
          set_cmd_done <= 1'b1;
          turn_cnt     <= SDH_RESUME_CLOCKS;
          if (pend_busy) st <= SDH_ST_BUSY;
          else if (cmd_r[SDH_CMD_DATA_BIT] || resume_wr) st <= SDH_ST_GAP;
          else st <= SDH_ST_IDLE;
        end
        SDH_ST_BUSY: if (rise && !card_busy) begin
          set_xfer_done <= 1'b1;
          st <= SDH_ST_IDLE;
        end
        SDH_ST_GAP: if (rise) begin
          // Never drive a resumed write onto a busy card
          if (turn_cnt != 4'h0) turn_cnt <= turn_cnt - 4'h1;
          else if (read_xfer || !card_busy) begin
            st      <= SDH_ST_DATA;
            tmo_cnt <= 16'h0000;
          end
        end
        SDH_ST_DATA: begin
          dat_oe <= !read_xfer;
          if (rise) dat_out <= ~dat_out;
          // The timeout does not count during a bus test (CMD19)
          if (rise && !bus_test) tmo_cnt <= tmo_cnt + 16'h0001;
          if (tmo_cnt == 16'(TMO_CLOCKS)) begin
            set_tmo <= 1'b1; st <= SDH_ST_IDLE;
          end
          if (blk_done && read_xfer) begin
            fifo_lvl <= fifo_lvl + 8'h01;
            if (fifo_lvl + 8'h01 >= 8'(FIFO_BLOCKS)) begin
              card_clk_en <= 1'b0;
              st <= SDH_ST_PAUSE;
            end
          end
          if (!read_xfer && mode_r[SDH_MODE_STREAM_BIT] && block_to_mem) begin
            turn_cnt <= SDH_TURN_CLOCKS;
            st       <= SDH_ST_DRAIN;
          end else if (blk_done && !mode_r[SDH_MODE_MULTI_BIT]) begin
            set_xfer_done <= 1'b1;
            bus_test <= 1'b0;
            auto_pend <= mode_r[SDH_MODE_ACMD_LSB +: 2] != SDH_ACMD_OFF;
            st <= SDH_ST_IDLE;
          end
        end
        SDH_ST_PAUSE: begin
          card_clk_en <= 1'b0;
          if (fifo_lvl < 8'(FIFO_BLOCKS)) begin
            // Stop request seen while paused ends at the gap
            if (gap_r[SDH_GAP_STOP_BIT]) begin
              set_gap <= 1'b1;
              st <= SDH_ST_IDLE;
            end else begin
              card_clk_en <= 1'b1;
              st <= SDH_ST_DATA;
            end
          end
        end
        SDH_ST_DRAIN: if (rise) begin
          // Last bits still in flight to the pins
          if (turn_cnt != 4'h0) turn_cnt <= turn_cnt - 4'h1;
          else begin
            card_clk_en <= 1'b0;
            dat_oe <= 1'b0;
            st <= SDH_ST_IDLE;
          end
        end
        default: st <= SDH_ST_IDLE;
      endcase
    end
  end

  // ***************************************************************
  // Status registers: set wins over a software clear
  // ***************************************************************
  logic clr_norm, clr_err;
  assign clr_norm = wr_go && aw_q == SDH_OFF_NORM_STAT;
  assign clr_err  = wr_go && aw_q == SDH_OFF_ERR_STAT;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      norm_stat <= SDH_RESET_ZERO; err_stat <= SDH_RESET_ZERO; resp_reg <= SDH_RESET_ZERO;
    end else begin
      norm_stat <= (clr_norm ? norm_stat & ~w_q : norm_stat) |
                   (32'(set_cmd_done) << SDH_NORM_CMD_DONE) |
                   (32'(set_xfer_done) << SDH_NORM_XFER_DONE) |
                   (32'(set_gap) << SDH_NORM_GAP_EVENT);
      err_stat  <= (clr_err ? err_stat & ~w_q : err_stat) |
                   (32'(set_tmo) << SDH_ERR_DATA_TMO);
      if (set_cmd_done) resp_reg <= {24'h000000, 2'h0, cmd_index};
    end
  end

  // ***************************************************************
  // AXI4-Lite read
  // ***************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0; s_axi_rvalid <= 1'b0;
      s_axi_rdata <= SDH_RESET_ZERO; s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        if (s_axi_araddr[7:2] <= SDH_OFF_GAP_CTRL[7:2]) begin
          s_axi_rdata <= sif.shadow[s_axi_araddr[4:2]];
        end else if (s_axi_araddr == SDH_OFF_NORM_STAT) begin
          s_axi_rdata <= norm_stat;
        end else if (s_axi_araddr == SDH_OFF_ERR_STAT) begin
          s_axi_rdata <= err_stat;
        end else if (s_axi_araddr == SDH_OFF_PRESENT) begin
          s_axi_rdata <= {24'h000000, 1'b0, st, card_busy, wp_s[1], cd_s[1], sif.pend};
        end else if (s_axi_araddr == SDH_OFF_RESPONSE) begin
          s_axi_rdata <= resp_reg;
        end else begin
          s_axi_rdata <= SDH_RESET_ZERO;
          s_axi_rresp <= 2'h2;
        end
      end
    end
  end
endmodule

/* tb/sdh_core_asserts.sv */
/*
  Port checker for sdh_core, bound to every instance.
  Assumes a free-running card clock on card_clk_in.
*/
`timescale 1ns/10ps
module sdh_core_asserts (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Card side
  input wire logic        card_clk_in,
  input wire logic        dat0_in,
  input wire logic        resp_end_in,
  input wire logic        cmd_start,
  input wire logic        dat_out,
  input wire logic        dat_oe
);
  logic [3:0] rises;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ********
  // Card rises since a response end; saturates so idle time never fires
  // ********
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rises <= 4'hF;
    end else if ($rose(resp_end_in)) begin
      rises <= 4'h0;
    end else if ($rose(card_clk_in) && rises != 4'hF) begin
      rises <= rises + 4'h1;
    end
  end
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data changed");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_W_ANSWER: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:400] s_axi_bvalid)
    else $error("write never answered");
  // One rise of slack for the pin synchroniser
  AST_CMD_GAP: assert property (cmd_start |-> rises >= 4'h7)
    else $error("command too soon after response");
  AST_CMD_PULSE: assert property (cmd_start |=> !cmd_start)
    else $error("command start longer than one cycle");
  AST_NO_DRIVE_BUSY: assert property (!dat0_in [*4] |-> !dat_oe)
    else $error("data driven while card busy");
  AST_RESET_IDLE: assert property ($rose(aresetn) |-> dat_out && !dat_oe && !cmd_start)
    else $error("outputs not idle after reset");
endmodule
bind sdh_core sdh_core_asserts u_asserts (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .card_clk_in, .dat0_in, .resp_end_in, .cmd_start,
  .dat_out, .dat_oe);

/* tb/sdh_card_model.sv */
/*
  Behavioural card: free card clock, response end and DAT0 busy.
  Assumes commands are announced by cmd_start on aclk.
*/
`timescale 1ns/10ps
module sdh_card_model
  import sdh_pkg::*;
(
  // Host side
  input  wire logic       aclk,
  input  wire logic       cmd_start,
  input  wire logic [5:0] cmd_index,
  // Card pins
  output logic            card_clk_in,
  output logic            dat0_in,
  output logic            resp_end_in,
  output logic            block_done_in
);
  logic b;
  initial begin
    card_clk_in = 1'b0;
    #3.7;
    forever #80 card_clk_in = ~card_clk_in;
  end
  initial begin
    // DAT0 has a pull-up, so released means high
    dat0_in = 1'b1;
    resp_end_in = 1'b0;
    block_done_in = 1'b0;
    forever begin
      @(posedge aclk iff cmd_start);
      b = cmd_index inside {SDH_CMD12, SDH_CMD28, SDH_CMD29, SDH_CMD38, SDH_CMD5, SDH_CMD6};
      repeat (3) @(posedge card_clk_in);
      resp_end_in <= 1'b1;
      @(posedge card_clk_in);
      resp_end_in <= 1'b0;
      if (b) begin
        dat0_in <= 1'b0;
        repeat (6) @(posedge card_clk_in);
        dat0_in <= 1'b1;
      end
    end
  end
endmodule

/* tb/sdh_core_tb_top.sv */
/*
  Testbench for sdh_core: registers, busy commands, crossings, soft reset.
  Assumes sdh_card_model on the card pins.
*/
`timescale 1ns/10ps
module sdh_core_tb_top;
  import sdh_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, card_detect_input = 1'b1;
  logic        write_protect_input = 1'b1, block_to_mem = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, cmd_arg, last_arg = 32'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        card_clk_in, dat0_in, resp_end_in, block_done_in, card_clk_en;
  logic        cmd_start, dat_out, dat_oe;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [5:0]  cmd_index;
  int          n_errors = 0, total_checks = 0, cycles = 0;

  sdh_core #(.FIFO_BLOCKS(2), .TMO_CLOCKS(16)) DUT (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .card_clk_in, .dat0_in, .resp_end_in, .block_done_in,
    .card_detect_input, .write_protect_input, .card_clk_en, .cmd_start, .cmd_index,
    .cmd_arg, .dat_out, .dat_oe, .block_to_mem);
  sdh_card_model u_card (.aclk, .cmd_start, .cmd_index, .card_clk_in, .dat0_in,
    .resp_end_in, .block_done_in);

  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cmd_start) begin
      last_arg <= cmd_arg;
    end
    if (cycles == 40000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  // ********
  // Bus tasks
  // ********
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    logic aw = 1'b0;
    logic w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready && !aw) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw && w && s_axi_bvalid));
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready && !ar) begin
        ar = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end while (!(ar && s_axi_rvalid));
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // Reads until the bit takes the value, bounded so a stuck flag still ends
  task automatic poll(input logic [7:0] a, input int b, input logic v, output logic [31:0] d);
    logic [1:0] r;
    int n = 0;
    do begin
      axr(a, d, r);
      n++;
    end while (d[b] !== v && n < 300);
  endtask
  task automatic tally_and_finish();
    if (n_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ********
  // Tests
  // ********
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [5:0]  idx [6];
    idx = '{SDH_CMD12, SDH_CMD28, SDH_CMD29, SDH_CMD38, SDH_CMD5, SDH_CMD6};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int a = 0; a < 9; a++) begin
      axr(8'(a * 4), d, r);
      check("reset value", 32'h0, d);
    end
    check("data idle", 32'h1, 32'(dat_out));
    axr(SDH_OFF_PRESENT, d, r);
    check("pins", 32'h6, d);
    card_detect_input <= 1'b0;
    // Let the pin pass its two synchroniser stages before reading it back
    repeat (3) @(posedge aclk);
    axr(SDH_OFF_PRESENT, d, r);
    check("pins", 32'h4, d);
    axw(8'h30, 32'h1, r);
    check("unmapped write", 32'h2, 32'(r));
    axr(8'h30, d, r);
    check("unmapped read", 32'h2, 32'(r));
    axw(SDH_OFF_XFER_MODE, 32'h0000_000C, r);
    axw(SDH_OFF_XFER_MODE, 32'h0, r);
    axw(SDH_OFF_ARGUMENT, 32'h1111_1111, r);
    axw(SDH_OFF_ARGUMENT, 32'h2222_2222, r);
    poll(SDH_OFF_PRESENT, 0, 1'b0, d);
    axr(SDH_OFF_XFER_MODE, d, r);
    check("auto command off", 32'h0, d);
    axr(SDH_OFF_ARGUMENT, d, r);
    check("argument", 32'h2222_2222, d);
    for (int i = 0; i < 6; i++) begin
      axw(SDH_OFF_HOST_CTRL, (i > 3) ? 32'h1 : 32'h0, r);
      axw(SDH_OFF_COMMAND, 32'(idx[i]) << SDH_CMD_IDX_LSB, r);
      poll(SDH_OFF_PRESENT, 3, 1'b1, d);
      check("busy seen", 32'h1, 32'(d[3]));
      check("no drive in busy", 32'h0, 32'(dat_oe));
      check("clock on", 32'h1, 32'(card_clk_en));
      axr(SDH_OFF_NORM_STAT, d, r);
      check("done in busy", 32'h0, 32'(d[SDH_NORM_XFER_DONE]));
      poll(SDH_OFF_NORM_STAT, SDH_NORM_XFER_DONE, 1'b1, d);
      check("done", 32'h1, 32'(d[SDH_NORM_XFER_DONE]));
      axr(SDH_OFF_PRESENT, d, r);
      check("busy released", 32'h0, 32'(d[3]));
      axr(SDH_OFF_RESPONSE, d, r);
      check("response index", 32'(idx[i]), d);
      check("command argument", 32'h2222_2222, last_arg);
      axw(SDH_OFF_NORM_STAT, 32'h7, r);
    end
    axw(SDH_OFF_COMMAND, 32'(SDH_CMD38) << SDH_CMD_IDX_LSB, r);
    poll(SDH_OFF_PRESENT, 3, 1'b1, d);
    check("state before soft reset", 32'h2, 32'(d[6:4]));
    axw(SDH_OFF_SW_RESET, 32'h1, r);
    axr(SDH_OFF_PRESENT, d, r);
    check("state after soft reset", 32'h0, 32'(d[6:4]));
    tally_and_finish();
  end
endmodule
